// *** conv_model.sv ***
/*
 * Behavioural converter on the far side of the conversion interface.
 * Assumes start is a one-cycle pulse; answers dly_in + 1 cycles after the start.
 */
`timescale 1ns/1ps
module conv_model (
	input  wire logic        clk_sys_in,  // System clock
	input  wire logic        start_in,    // Convert pulse
	input  wire logic [5:0]  chan_in,     // Channel to convert
	input  wire logic        gain10_in,   // Gain x10 select
	input  wire logic [7:0]  dly_in,      // Cycles until result, less one
	output logic             done_out,    // Result pulse
	output logic [15:0]      data_out,    // Result word
	output int               n_start_out, // Starts seen
	output int               n_done_out   // Results given
);
	logic [15:0] res_reg;
	logic        busy;
	int          cnt;
	// Idle state before the first start
	initial begin
		done_out = 1'b0;
		data_out = 16'h0000;
		res_reg = 16'h0000;
		n_start_out = 0;
		n_done_out = 0;
		busy = 1'b0;
		cnt = 0;
	end
	// Result carries channel and gain so every buffer word shows its source
	always @(posedge clk_sys_in) begin
		done_out <= 1'b0;
		data_out <= ~data_out; // Released lines churn, never hold a stale result
		if (start_in) begin
			busy <= 1'b1;
			cnt <= dly_in;
			res_reg <= {1'b1, gain10_in, 8'h00, chan_in};
			n_start_out <= n_start_out + 1;
		end else if (busy && cnt == 0) begin
			busy <= 1'b0;
			done_out <= 1'b1;
			data_out <= res_reg;
			n_done_out <= n_done_out + 1;
		end else if (busy) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// *** scan_buffer_config.sv ***
/*
 * Scan configuration and sequencing: register window, layout decode,
 * trigger selection, conversion sequencing into the sample buffer.
 * Assumes bus master and converter run on clk_sys_in; only the external
 * trigger pin is asynchronous.
 */
`timescale 1ns/1ps
module scan_buffer_config
	import scan_pkg::*;
(
	input  wire logic              clk_sys_in,      // System clock, 200 MHz
	input  wire logic              rst_n_in,        // Bus reset, active low
	input  wire logic              bus_req_in,      // Access request, held to ack
	input  wire logic              bus_wr_in,       // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] bus_addr_in,     // Byte address
	input  wire logic [DATA_W-1:0] bus_wdata_in,    // Write data
	output logic      [DATA_W-1:0] bus_rdata_out,   // Read data, valid with ack
	output logic                   bus_ack_out,     // One-cycle access done
	input  wire logic              ext_trig_in,     // External trigger pin
	input  wire logic              timer_tick_in,   // Interval timer pulse
	input  wire logic              count_hit_in,    // Data counter reached
	input  wire logic              irq_enable_in,   // Interrupt enable
	output logic                   irq_req_out,     // Bus interrupt request
	output logic                   conv_start_out,  // One-cycle convert pulse
	output logic      [CHAN_W-1:0] conv_chan_out,   // Channel to convert
	output logic                   conv_gain10_out, // 1 gain x10, 0 gain x1
	input  wire logic              conv_done_in,    // Result valid pulse
	input  wire logic [DATA_W-1:0] conv_data_in     // Conversion result
);
	// Split a layout code into {log2 buffer size, log2 block size}
	function automatic logic [7:0] decode_layout(input logic [4:0] code);
		logic [4:0] rel;
		logic [4:0] run;
		logic [4:0] pos;
		logic [3:0] size_l2;
		logic [3:0] blk_l2;
		rel = 5'h00;
		run = 5'h00;
		pos = 5'h00;
		if (code < 5'h03) begin
			size_l2 = 4'h4;
			pos = code;
		end else if (code < LAYOUT_FIRST_BIG) begin
			size_l2 = 4'h5;
			pos = code - 5'h03;
		end else begin
			rel = code - LAYOUT_FIRST_BIG;
			run = rel / LAYOUTS_PER_SIZE;
			pos = rel % LAYOUTS_PER_SIZE;
			size_l2 = 4'h6 + run[3:0];
		end
		case (pos)
			5'h00:   blk_l2 = 4'h0;
			5'h01:   blk_l2 = 4'h3;
			5'h02:   blk_l2 = 4'h4;
			5'h03:   blk_l2 = 4'h5;
			default: blk_l2 = 4'h6;
		endcase
		return {size_l2, blk_l2};
	endfunction

	scan_state_e       state_reg, state_next;
	logic [15:0]       cfg_reg, cfg_next;
	logic [15:0]       csr_reg, csr_next;
	logic [63:0]       gain_reg, gain_next;
	logic [BUF_AW-1:0] idx_reg, idx_next;
	logic              rdy_reg, rdy_next;
	logic              trig_reg, trig_next;
	logic              start_reg, start_next;
	logic [CHAN_W-1:0] chan_reg, chan_next;
	logic              gain10_reg, gain10_next;
	logic              irq_reg, irq_next;
	logic [2:0]        ext_sync_reg;
	logic              s1_reg, s1_next;
	logic              s1_wr_reg, s1_wr_next;
	logic [ADDR_W-1:0] s1_addr_reg, s1_addr_next;
	logic              ack_reg, ack_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;

	logic [7:0]        layout;
	logic [3:0]        size_l2, blk_l2;
	logic [BUF_AW-1:0] last_word, half_word;
	logic [CHAN_W-1:0] blk_mask, group, scan_chan;
	logic              random_mode, auto_mode;
	logic              in_buf, in_mem_range, bus_buf_wr, take;
	logic              trigger, sw_reset, scan_we;
	logic              rdy_set;
	logic [BUF_AW-1:0] scan_waddr;
	logic [DATA_W-1:0] mem_q;

	// Layout decode; with blocks of 8 or more, group bits outside the block's index reach the channel only in random access mode
	always_comb begin
		layout      = decode_layout(cfg_reg[CFG_LAYOUT_LSB +: 5]);
		size_l2     = layout[7:4];
		blk_l2      = layout[3:0];
		last_word   = BUF_AW'((11'h001 << size_l2) - 11'h001);
		half_word   = last_word >> 1;
		blk_mask    = CHAN_W'((7'h01 << blk_l2) - 7'h01);
		group       = cfg_reg[CFG_GROUP_LSB +: CHAN_W];
		random_mode = cfg_reg[CFG_SMODE_LSB + 1];
		auto_mode   = (cfg_reg[CFG_SMODE_LSB +: 2] == SMODE_AUTO);
		if (blk_l2 == 4'h0) begin
			scan_chan = group;
		end else begin
			// Bits 2..0 name an 8-channel block, wider blocks drop the low ones; bits 5..3 are ignored
			scan_chan = ({group[2:0], 3'h0} & ~blk_mask)
				| (idx_reg[CHAN_W-1:0] & blk_mask);
		end
	end

	// Bus decode; a buffer write waits a cycle if the scan owns the write port
	always_comb begin
		in_buf       = (bus_addr_in >= OFS_BUF_LO) && (bus_addr_in <= OFS_BUF_HI);
		in_mem_range = (bus_addr_in >= OFS_BUF_LO) && (bus_addr_in <= OFS_RAM_HI);
		bus_buf_wr   = bus_wr_in && in_buf;
		take         = bus_req_in && !s1_reg && !ack_reg && !(bus_buf_wr && scan_we);
		sw_reset     = take && bus_wr_in && (bus_addr_in == OFS_SW_RESET);
		case (csr_reg[CSR_TMODE_LSB +: 2])
			TMODE_SW:    trigger = take && bus_wr_in && (bus_addr_in == OFS_SW_TRIGGER);
			TMODE_EXT:   trigger = ext_sync_reg[1] && !ext_sync_reg[2];
			TMODE_TIMER: trigger = timer_tick_in;
			default:     trigger = 1'b0;
		endcase
	end

	// Scan sequencer; the result write happens on the converter's done pulse
	always_comb begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		rdy_next    = rdy_reg;
		trig_next   = trig_reg;
		start_next  = 1'b0;
		chan_next   = chan_reg;
		gain10_next = gain10_reg;
		scan_we     = 1'b0;
		rdy_set     = 1'b0;
		scan_waddr  = random_mode ? '0 : idx_reg;
		case (state_reg)
			ST_ARMED: begin
				if (trigger) begin
					trig_next  = 1'b1;
					idx_next   = '0;
					state_next = ST_START;
				end
			end
			ST_START: begin
				start_next = 1'b1;
				chan_next  = random_mode ? group : scan_chan;
				if (cfg_reg[CFG_GMODE_LSB + 1]) begin
					gain10_next = gain_reg[chan_next];
				end else begin
					gain10_next = cfg_reg[CFG_GMODE_LSB];
				end
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (conv_done_in) begin
					scan_we = 1'b1;
					if (random_mode) begin
						rdy_set    = 1'b1;
						rdy_next   = 1'b1;
						trig_next  = 1'b0;
						state_next = ST_ARMED;
					end else if (idx_reg == last_word) begin
						idx_next = '0;
						if (!csr_reg[CSR_FLAG_BIT]) begin
							rdy_set  = 1'b1;
							rdy_next = 1'b1;
						end
						if (auto_mode) begin
							state_next = ST_START;
						end else begin
							trig_next  = 1'b0;
							state_next = ST_ARMED;
						end
					end else begin
						if (csr_reg[CSR_FLAG_BIT] && idx_reg == half_word) begin
							rdy_set  = 1'b1;
							rdy_next = 1'b1;
						end
						idx_next   = idx_reg + BUF_AW'(1);
						state_next = ST_START;
					end
				end
			end
			default: state_next = ST_ARMED;
		endcase
		// A read clears the flag only when no set lands in the same cycle;
		// the set wins even if the flag was already up, so no event is lost
		if (take && !bus_wr_in && in_mem_range && !rdy_set) begin
			rdy_next = 1'b0;
		end
		if (sw_reset) begin
			state_next = ST_ARMED;
			idx_next   = '0;
			rdy_next   = 1'b0;
			trig_next  = 1'b0;
		end
	end

	// Register writes and the two-stage read pipeline
	always_comb begin
		cfg_next     = cfg_reg;
		csr_next     = csr_reg;
		gain_next    = gain_reg;
		s1_next      = take;
		s1_wr_next   = bus_wr_in;
		s1_addr_next = bus_addr_in;
		ack_next     = s1_reg;
		rdata_next   = '0;
		if (take && bus_wr_in) begin
			case (bus_addr_in)
				OFS_SCAN_CONFIG: cfg_next = bus_wdata_in;
				OFS_CSR:         csr_next = bus_wdata_in & CSR_WR_MASK;
				OFS_AUTO_GAIN:   gain_next[bus_wdata_in[GAIN_CHAN_LSB +: CHAN_W]] =
					bus_wdata_in[GAIN_BIT];
				default:         cfg_next = cfg_reg;
			endcase
		end
		if (sw_reset) begin
			cfg_next = CFG_RESET;
			csr_next = CSR_RESET;
		end
		if (s1_reg && !s1_wr_reg) begin
			if (s1_addr_reg >= OFS_BUF_LO && s1_addr_reg <= OFS_BUF_HI) begin
				rdata_next = mem_q;
			end else begin
				case (s1_addr_reg)
					OFS_SCAN_CONFIG: rdata_next = cfg_reg;
					OFS_CSR: begin
						rdata_next = csr_reg;
						rdata_next[CSR_RDY_BIT]   = rdy_reg;
						rdata_next[CSR_ARMED_BIT] = (state_reg == ST_ARMED);
						rdata_next[CSR_TRIG_BIT]  = trig_reg;
					end
					OFS_AUTO_GAIN:   rdata_next = gain_reg[15:0];
					default:         rdata_next = '0;
				endcase
			end
		end
		// Interrupt origin is chosen here; enable logic lives outside
		irq_next = irq_enable_in
			&& (cfg_reg[CFG_ISRC_BIT] ? count_hit_in : rdy_reg);
	end

	// State registers; bus reset brings everything to its idle value
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg    <= ST_ARMED;
			cfg_reg      <= CFG_RESET;
			csr_reg      <= CSR_RESET;
			gain_reg     <= GAIN_RESET;
			idx_reg      <= '0;
			rdy_reg      <= 1'b0;
			trig_reg     <= 1'b0;
			start_reg    <= 1'b0;
			chan_reg     <= '0;
			gain10_reg   <= 1'b0;
			irq_reg      <= 1'b0;
			ext_sync_reg <= 3'h0;
			s1_reg       <= 1'b0;
			s1_wr_reg    <= 1'b0;
			s1_addr_reg  <= '0;
			ack_reg      <= 1'b0;
			rdata_reg    <= '0;
		end else begin
			state_reg    <= state_next;
			cfg_reg      <= cfg_next;
			csr_reg      <= csr_next;
			gain_reg     <= gain_next;
			idx_reg      <= idx_next;
			rdy_reg      <= rdy_next;
			trig_reg     <= trig_next;
			start_reg    <= start_next;
			chan_reg     <= chan_next;
			gain10_reg   <= gain10_next;
			irq_reg      <= irq_next;
			ext_sync_reg <= {ext_sync_reg[1:0], ext_trig_in};             // Edge seen on [1]/[2]
			s1_reg       <= s1_next;
			s1_wr_reg    <= s1_wr_next;
			s1_addr_reg  <= s1_addr_next;
			ack_reg      <= ack_next;
			rdata_reg    <= rdata_next;
		end
	end

	scan_word_store u_store (
		.clk_sys_in  (clk_sys_in),
		.wr_en_in    (scan_we || (take && bus_buf_wr)),
		.wr_addr_in  (scan_we ? scan_waddr : BUF_AW'((bus_addr_in - OFS_BUF_LO) >> 1)),
		.wr_data_in  (scan_we ? conv_data_in : bus_wdata_in),
		.rd_addr_in  (BUF_AW'((bus_addr_in - OFS_BUF_LO) >> 1)),
		.rd_data_out (mem_q)
	);

	assign bus_rdata_out   = rdata_reg;
	assign bus_ack_out     = ack_reg;
	assign irq_req_out     = irq_reg;
	assign conv_start_out  = start_reg;
	assign conv_chan_out   = chan_reg;
	assign conv_gain10_out = gain10_reg;

	property p_random_word0;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		scan_we && random_mode && !sw_reset
			|-> scan_waddr == '0 ##1 (state_reg == ST_ARMED && rdy_reg);
	endproperty
	a_random_word0: assert property (p_random_word0) else $error("random result not at word 0");

	property p_read_clears;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		take && !bus_wr_in && in_mem_range && !scan_we |=> !rdy_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("ready flag survived read");

	property p_irq_source;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		irq_enable_in && cfg_reg[CFG_ISRC_BIT] |=> irq_req_out == $past(count_hit_in);
	endproperty
	a_irq_source: assert property (p_irq_source) else $error("irq not from counter");

	property p_fixed_gain;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_reg == ST_START && !cfg_reg[CFG_GMODE_LSB + 1]
			|=> conv_start_out && conv_gain10_out == $past(cfg_reg[CFG_GMODE_LSB]);
	endproperty
	a_fixed_gain: assert property (p_fixed_gain) else $error("fixed gain wrong");

	property p_sw_reset;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		sw_reset |=> cfg_reg == 16'h0000 && state_reg == ST_ARMED;
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("soft reset left config");

	property p_single_stop;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		scan_we && !random_mode && !auto_mode && idx_reg == last_word && !sw_reset
			|=> state_reg == ST_ARMED ##1 (state_reg == ST_ARMED || $past(trigger));
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single scan did not stop");

	property p_auto_rearm;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		scan_we && auto_mode && idx_reg == last_word && !sw_reset
			|=> idx_reg == '0 ##1 conv_start_out;
	endproperty
	a_auto_rearm: assert property (p_auto_rearm) else $error("auto scan did not restart");

	property p_step;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		scan_we && !random_mode && idx_reg != last_word && !sw_reset
			|=> idx_reg == $past(idx_reg) + BUF_AW'(1);
	endproperty
	a_step: assert property (p_step) else $error("buffer index did not step");
endmodule

// *** scan_buffer_config_tb.sv ***
/*
 * Self-checking bench for the scan configuration block.
 * Assumes the converter model answers every start; bus is one access at a time.
 */
`timescale 1ns/1ps
module scan_buffer_config_tb;
	import scan_pkg::*;
	logic              clk_sys_in;
	logic              rst_n_in;
	logic              req;
	logic              wr_sel;
	logic [11:0]       addr;
	logic [15:0]       wdata;
	logic [15:0]       rdata;
	logic              ack;
	logic              ext_trig;
	logic              timer_tick;
	logic              count_hit;
	logic              irq_en;
	logic              irq;
	logic              c_start;
	logic [5:0]        c_chan;
	logic              c_g10;
	logic              c_done;
	logic [15:0]       c_data;
	logic [7:0]        dly;
	int                n_st;
	int                n_dn;
	int                failures;
	int                n_compared;

	scan_buffer_config dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.bus_req_in(req), .bus_wr_in(wr_sel), .bus_addr_in(addr),
		.bus_wdata_in(wdata), .bus_rdata_out(rdata), .bus_ack_out(ack),
		.ext_trig_in(ext_trig), .timer_tick_in(timer_tick),
		.count_hit_in(count_hit), .irq_enable_in(irq_en), .irq_req_out(irq),
		.conv_start_out(c_start), .conv_chan_out(c_chan),
		.conv_gain10_out(c_g10), .conv_done_in(c_done), .conv_data_in(c_data));
	conv_model conv_u (.clk_sys_in(clk_sys_in), .start_in(c_start),
		.chan_in(c_chan), .gain10_in(c_g10), .dly_in(dly), .done_out(c_done),
		.data_out(c_data), .n_start_out(n_st), .n_done_out(n_dn));

	// 200 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Request held until ack is sampled; data taken at that same edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
			output logic [15:0] q);
		int i;
		req <= 1'b1;
		wr_sel <= w;
		addr <= a;
		wdata <= d;
		q = 16'h0000;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys_in);
			if (ack === 1'b1) break;
		end
		if (i == 20) begin
			failures++;
			finish_test();
		end
		q = rdata;
		req <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, output logic [15:0] q);
		bus(1'b0, a, 16'h0000, q);
	endtask

	// Poll the ready bit; reading status does not clear it
	task automatic wait_rdy();
		logic [15:0] q;
		int i;
		q = 16'h0000;
		for (i = 0; i < 400 && q[6] !== 1'b1; i++) rd(12'h002, q);
		if (q[6] !== 1'b1) begin
			failures++;
			finish_test();
		end
	endtask

	// Single scan of nw words; gs is the x10 channel, 64 for all, -1 for none
	task automatic scan(input logic [15:0] cfg, input int nw, input logic [5:0] b,
			input logic [5:0] m, input int gs);
		logic [15:0] q;
		logic [15:0] e;
		logic [5:0]  c;
		int          i;
		int          n0;
		wr(12'h004, cfg);
		rd(12'h004, q);
		chk("config", cfg, q);
		wr(12'h080 + 12'(2 * nw), 16'h5a5a);
		n0 = n_st;
		wr(12'h00e, 16'h0001);
		wait_rdy();
		repeat (40) @(posedge clk_sys_in);
		chk("starts", 16'(nw), 16'(n_st - n0));
		for (i = 0; i < nw; i++) begin
			c = (b & ~m) | 6'(i & m);
			e = {1'b1, 1'(gs == 64 || gs == c), 8'h00, c};
			rd(12'h080 + 12'(2 * i), q);
			chk("word", e, q);
		end
		rd(12'h080 + 12'(2 * nw), q);
		chk("beyond", 16'h5a5a, q);
		rd(12'h002, q);
		chk("ready", 16'h0000, q & 16'h0040);
		$display("scan %h done", cfg);
	endtask

	task automatic irq_test();
		logic [15:0] q;
		irq_en <= 1'b1;
		wr(12'h004, 16'h0400);
		count_hit <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		chk("irq count", 16'h0001, 16'(irq));
		wr(12'h004, 16'h0040);
		repeat (2) @(posedge clk_sys_in);
		chk("irq idle", 16'h0000, 16'(irq));
		wr(12'h00e, 16'h0001);
		wait_rdy();
		repeat (2) @(posedge clk_sys_in);
		chk("irq ready", 16'h0001, 16'(irq));
		rd(12'h080, q);
		repeat (2) @(posedge clk_sys_in);
		chk("irq clear", 16'h0000, 16'(irq));
		count_hit <= 1'b0;
		irq_en <= 1'b0;
		$display("irq test done");
	endtask

	// Slow converter so the half-way flag is seen before the end
	task automatic half_test();
		int i;
		int n0;
		wr(12'h002, 16'h0400);
		dly <= 8'd20;
		n0 = n_dn;
		wr(12'h00e, 16'h0001);
		wait_rdy();
		chk("half", 16'h0001, 16'(n_dn - n0 >= 8 && n_dn - n0 < 16));
		for (i = 0; i < 1000 && n_dn - n0 < 16; i++) @(posedge clk_sys_in);
		dly <= 8'd0;
		wr(12'h002, 16'h0000);
		$display("half test done");
	endtask

	// Random access under every trigger select, reserved one included
	task automatic trig_test();
		logic [15:0] q;
		int          k;
		int          i;
		int          n0;
		wr(12'h004, 16'h00b2);
		wr(12'h082, 16'h5a5a);
		for (k = 0; k < 4; k++) begin
			wr(12'h002, 16'(k) << 12);
			n0 = n_dn;
			if (k == 0) wr(12'h00e, 16'h0001);
			ext_trig <= (k == 1);
			timer_tick <= (k == 2);
			@(posedge clk_sys_in);
			timer_tick <= 1'b0;
			for (i = 0; i < 40 && n_dn == n0; i++) @(posedge clk_sys_in);
			ext_trig <= 1'b0;
			chk("trigger", 16'(k != 3), 16'(n_dn - n0));
		end
		rd(12'h080, q);
		chk("random word", 16'h8032, q);
		rd(12'h082, q);
		chk("random next", 16'h5a5a, q);
		wr(12'h002, 16'h0000);
		$display("trigger test done");
	endtask

	task automatic auto_test();
		logic [15:0] q;
		int          i;
		int          n0;
		wr(12'h004, 16'h0003);
		n0 = n_dn;
		wr(12'h00e, 16'h0001);
		for (i = 0; i < 2000 && n_dn - n0 < 40; i++) @(posedge clk_sys_in);
		chk("rearm", 16'h0001, 16'(n_dn - n0 >= 40));
		wr(12'h00c, 16'h0000);
		rd(12'h004, q);
		chk("soft reset", 16'h0000, q);
		$display("auto test done");
	endtask

	// Main sequence
	initial begin
		logic [15:0] q;
		failures = 0;
		n_compared = 0;
		rst_n_in = 1'b0;
		req = 1'b0;
		wr_sel = 1'b0;
		addr = 12'h000;
		wdata = 16'h0000;
		ext_trig = 1'b0;
		timer_tick = 1'b0;
		count_hit = 1'b0;
		irq_en = 1'b0;
		dly = 8'd0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		rd(12'h004, q);
		chk("config reset", 16'h0000, q);
		rd(12'h010, q);
		chk("gain reset", 16'h0000, q);
		scan(16'h0047, 16, 6'd7, 6'd0, -1);
		scan(16'h087b, 16, 6'd24, 6'd7, -1);
		scan(16'h107d, 16, 6'd32, 6'd15, -1);
		scan(16'h196d, 32, 6'd45, 6'd0, 64);
		scan(16'h2041, 32, 6'd8, 6'd7, -1);
		scan(16'h2842, 32, 6'd16, 6'd15, -1);
		scan(16'h3044, 32, 6'd32, 6'd31, -1);
		wr(12'h010, 16'h0901);
		rd(12'h010, q);
		chk("gain table", 16'h0200, q);
		scan(16'h0b41, 16, 6'd8, 6'd7, 9);
		irq_test();
		half_test();
		trig_test();
		auto_test();
		finish_test();
	end
endmodule

// *** scan_pkg.sv ***
/*
 * Shared constants for the scan configuration block: register offsets,
 * field positions, reset values, trigger and scan mode codes, states.
 * Assumes a 16-bit register bus with byte addresses in a 4 KB window.
 */
package scan_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int BUF_AW = 10;
	localparam int CHAN_W = 6;

	// Byte offsets of the register window
	localparam logic [11:0] OFS_CSR         = 12'h002;
	localparam logic [11:0] OFS_SCAN_CONFIG = 12'h004;
	localparam logic [11:0] OFS_SW_RESET    = 12'h00c;
	localparam logic [11:0] OFS_SW_TRIGGER  = 12'h00e;
	localparam logic [11:0] OFS_AUTO_GAIN   = 12'h010;
	localparam logic [11:0] OFS_BUF_LO      = 12'h080;
	localparam logic [11:0] OFS_BUF_HI      = 12'h87e;
	localparam logic [11:0] OFS_RAM_HI      = 12'hffe;

	// Field positions inside scan_config
	localparam int CFG_LAYOUT_LSB = 11;
	localparam int CFG_ISRC_BIT   = 10;
	localparam int CFG_GMODE_LSB  = 8;
	localparam int CFG_SMODE_LSB  = 6;
	localparam int CFG_GROUP_LSB  = 0;

	// Field positions inside the control and status register
	localparam int CSR_TMODE_LSB = 12;
	localparam int CSR_FLAG_BIT  = 10;
	localparam int CSR_RDY_BIT   = 6;
	localparam int CSR_ARMED_BIT = 5;
	localparam int CSR_TRIG_BIT  = 4;
	localparam logic [15:0] CSR_WR_MASK = 16'hfc00;

	// Auto gain write layout: channel number and gain bit
	localparam int GAIN_CHAN_LSB = 8;
	localparam int GAIN_BIT      = 0;

	// Values after reset
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CSR_RESET = 16'h0000;
	localparam logic [63:0] GAIN_RESET = 64'h0000_0000_0000_0000;

	// Layout codes of the buffers of 64 words and above come in runs of five
	localparam logic [4:0] LAYOUT_FIRST_BIG = 5'h07;
	localparam logic [4:0] LAYOUTS_PER_SIZE = 5'h05;

	// Trigger select codes
	localparam logic [1:0] TMODE_SW    = 2'h0;
	localparam logic [1:0] TMODE_EXT   = 2'h1;
	localparam logic [1:0] TMODE_TIMER = 2'h2;

	// Scan mode codes (upper bit alone selects random access)
	localparam logic [1:0] SMODE_AUTO   = 2'h0;
	localparam logic [1:0] SMODE_SINGLE = 2'h1;

	typedef enum logic [2:0] {
		ST_ARMED = 3'b001,
		ST_START = 3'b010,
		ST_WAIT  = 3'b100
	} scan_state_e;
endpackage

// *** scan_word_store.sv ***
/*
 * 1024 x 16 sample buffer with one write port and one registered read port.
 * Assumes the caller resolves write collisions; no reset on the array.
 */
`timescale 1ns/1ps
module scan_word_store
	import scan_pkg::*;
(
	input  wire logic              clk_sys_in,   // System clock
	input  wire logic              wr_en_in,     // Write strobe
	input  wire logic [BUF_AW-1:0] wr_addr_in,   // Write word index
	input  wire logic [DATA_W-1:0] wr_data_in,   // Write data
	input  wire logic [BUF_AW-1:0] rd_addr_in,   // Read word index
	output logic      [DATA_W-1:0] rd_data_out   // Read data, one cycle later
);
	logic [DATA_W-1:0] mem [0:(1<<BUF_AW)-1];
	logic [DATA_W-1:0] rd_data_reg;

	// Plain synchronous array so it maps onto block memory
	always_ff @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_reg <= mem[rd_addr_in];
	end

	assign rd_data_out = rd_data_reg;
endmodule
